// File: rofc_core.sv
// rofc_core.sv: on-time modulation, dead-time and fault protection core
// assumes analog comparators on pins and gate drivers downstream
`timescale 1ns/100ps
`include "rofc_defs.svh"

module rofc_core
    import rofc_pkg::*;
#(
    parameter bit          USE_COUNTER   = 1'b0,
    parameter bit          CUMULATIVE    = 1'b0,
    parameter bit          LATCHED       = 1'b0,
    parameter int unsigned DEAD_CYC      = `ROFC_DEAD_CYC_DEF,
    parameter int unsigned LEB_CYC       = `ROFC_LEB_CYC_DEF,
    parameter int unsigned FB_TIMER_CYC  = `ROFC_FB_TIMER_DEF,
    parameter int unsigned FB_COUNT_LIM  = `ROFC_FB_COUNT_DEF,
    parameter int unsigned SC_LIMIT      = `ROFC_SC_LIMIT_DEF,
    parameter int unsigned AREC_CYC      = `ROFC_AREC_CYC_DEF
)(
    // clock and reset (reset is the undervoltage lockout)
    input  wire logic        clock,
    input  wire logic        srst,
    // asynchronous comparator pins
    input  wire rofc_cmp_t   cmp_pins,
    // control levels from the same clock domain
    input  wire logic        run_enable,
    input  wire logic        startup_active,
    input  wire logic        skip_mode,
    input  wire logic        supply_reset,
    // gate drives and analog steering
    output rofc_gate_t       gate_drive,
    output logic             ref_soft_start_sel,
    output logic             feed_forward_current_en,
    // status
    output rofc_fault_t      fault_state,
    output logic [`ROFC_ON_W-1:0] on_time_last
);

    // ************************************************************
    // input synchronisation
    // ************************************************************
    logic trip_s;
    logic fbf_s;
    logic csf_s;
    logic lok_s;
    logic fbf_f;

    // every comparator passes the synchroniser
    rofc_sync u_sync_trip (.clock(clock), .srst(srst), .pin_in(cmp_pins.on_time_trip),
                           .level_out(trip_s));
    rofc_sync u_sync_fbf  (.clock(clock), .srst(srst), .pin_in(cmp_pins.fb_fault),
                           .level_out(fbf_s));
    rofc_sync u_sync_csf  (.clock(clock), .srst(srst), .pin_in(cmp_pins.cs_fault),
                           .level_out(csf_s));
    rofc_sync u_sync_lok  (.clock(clock), .srst(srst), .pin_in(cmp_pins.line_ok_flag),
                           .level_out(lok_s));

    // feedback fault noise filter
    rofc_filter u_fb_filt (.clock(clock), .srst(srst), .raw_in(fbf_s),
                           .filt_out(fbf_f));

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [31:0] inc32(input logic [31:0] v);
        return (v == 32'hFFFFFFFF) ? v : v + 32'h1;
    endfunction : inc32

    // ************************************************************
    // phase machine
    // ************************************************************
    rofc_phase_t              phase_q;
    rofc_phase_t              phase_d;
    logic [`ROFC_ON_W-1:0]    on_cnt_q;
    logic [`ROFC_ON_W-1:0]    on_cnt_d;
    logic [`ROFC_ON_W-1:0]    last_q;
    logic [`ROFC_ON_W-1:0]    last_d;
    logic [`ROFC_ON_W-1:0]    tmr_q;
    logic [`ROFC_ON_W-1:0]    tmr_d;
    logic                     trip_seen_q;
    logic                     trip_seen_d;
    logic                     reuse_q;
    logic                     reuse_d;
    logic                     stopped;

    // on-time steps of 10 ns at a 25 ns clock: per cycle add 25/10, truncated to 2 steps
    localparam logic [`ROFC_ON_W-1:0] STEP_PER_CYC =
        `ROFC_ON_W'((`ROFC_CLK_PERIOD_PS / 1000) / `ROFC_ON_STEP_NS);
    localparam logic [`ROFC_ON_W-1:0] DEAD_W = `ROFC_ON_W'(DEAD_CYC);
    localparam logic [`ROFC_ON_W-1:0] LEB_W  = `ROFC_ON_W'(LEB_CYC);
    localparam logic [`ROFC_ON_W-1:0] ON_MAX = {`ROFC_ON_W{1'b1}};

    wire leb_over    = (tmr_q >= LEB_W);
    wire trip_valid  = trip_s && leb_over;
    wire stuck_trip  = trip_s && !leb_over && trip_seen_q;
    wire reuse       = reuse_q || stuck_trip;
    wire dead_over   = (tmr_q >= DEAD_W - `ROFC_ON_W'(1));
    wire upper_start = (phase_q == ROFC_ST_DT_HI) && dead_over && !stopped;
    wire upper_end;

    // a stuck comparator holds the upper on for the stored on-time
    assign upper_end = (phase_q == ROFC_ST_UPPER) &&
                       ((reuse ? (on_cnt_q >= last_q) : trip_valid) || on_cnt_q == ON_MAX);

    // next phase and counters
    always_comb begin
        phase_d     = phase_q;
        on_cnt_d    = on_cnt_q;
        last_d      = last_q;
        tmr_d       = tmr_q + `ROFC_ON_W'(1);
        trip_seen_d = trip_seen_q;
        reuse_d     = reuse_q;
        unique case (phase_q)
            ROFC_ST_IDLE: begin
                tmr_d = '0;
                if (!stopped) begin
                    phase_d = ROFC_ST_DT_HI;
                end
            end
            ROFC_ST_DT_HI: begin
                if (stopped) begin
                    phase_d = ROFC_ST_IDLE;
                end else if (upper_start) begin
                    phase_d  = ROFC_ST_UPPER;
                    on_cnt_d = '0;
                    tmr_d    = '0;
                    reuse_d  = 1'b0;
                end
            end
            ROFC_ST_UPPER: begin
                on_cnt_d = (on_cnt_q > ON_MAX - STEP_PER_CYC) ? ON_MAX
                                                              : on_cnt_q + STEP_PER_CYC;
                reuse_d  = reuse;
                if (stopped) begin
                    phase_d = ROFC_ST_IDLE;
                end else if (upper_end) begin
                    phase_d = ROFC_ST_DT_LO;
                    tmr_d   = '0;
                    if (reuse) begin
                        on_cnt_d = last_q;
                    end else begin
                        last_d   = on_cnt_q;
                        on_cnt_d = on_cnt_q;
                    end
                    trip_seen_d = 1'b1;
                end
            end
            ROFC_ST_DT_LO: begin
                if (stopped) begin
                    phase_d = ROFC_ST_IDLE;
                end else if (dead_over) begin
                    phase_d = ROFC_ST_LOWER;
                end
            end
            ROFC_ST_LOWER: begin
                on_cnt_d = (on_cnt_q > STEP_PER_CYC) ? on_cnt_q - STEP_PER_CYC : '0;
                if (stopped) begin
                    phase_d = ROFC_ST_IDLE;
                end else if (on_cnt_q < STEP_PER_CYC) begin
                    phase_d = ROFC_ST_DT_HI;
                    tmr_d   = '0;
                end
            end
        endcase
    end

    // phase registers
    always_ff @(posedge clock) begin
        if (srst) begin
            phase_q     <= ROFC_ST_IDLE;
            on_cnt_q    <= '0;
            last_q      <= '0;
            tmr_q       <= '0;
            trip_seen_q <= 1'b0;
            reuse_q     <= 1'b0;
        end else begin
            phase_q     <= phase_d;
            on_cnt_q    <= on_cnt_d;
            last_q      <= last_d;
            tmr_q       <= (tmr_d == ON_MAX) ? tmr_q : tmr_d;
            trip_seen_q <= trip_seen_d;
            reuse_q     <= reuse_d;
        end
    end

    // ************************************************************
    // feedback fault confirmation
    // ************************************************************
    logic [31:0] fb_cnt_q;
    logic        prot_q;
    logic        latch_q;
    logic [31:0] arec_q;
    logic        fb_confirm;
    logic        sc_overflow;
    wire         upper_pulse = upper_start;  // one per upper gate pulse
    wire  [31:0] fb_limit    = USE_COUNTER ? FB_COUNT_LIM : FB_TIMER_CYC;
    wire         fb_step     = USE_COUNTER ? upper_pulse : 1'b1;

    assign fb_confirm = fbf_f && (fb_cnt_q >= fb_limit - 32'h1) && fb_step;

    // timer or counter with cumulative option
    always_ff @(posedge clock) begin
        if (srst || skip_mode) begin
            fb_cnt_q <= '0;
        end else if (fbf_f) begin
            if (fb_step) begin
                fb_cnt_q <= inc32(fb_cnt_q);
            end
        end else if (!CUMULATIVE) begin
            fb_cnt_q <= '0;
        end  // otherwise held
    end

    // ************************************************************
    // short-circuit counter
    // ************************************************************
    logic [31:0] sc_cnt_q;
    logic [7:0]  quiet_q;
    logic        csf_d1_q;
    logic        cs_in_pulse_q;
    wire         cs_rise = csf_s && !csf_d1_q;

    assign sc_overflow = cs_rise && (sc_cnt_q >= SC_LIMIT - 32'h1);

    // count trips and quiet upper pulses
    always_ff @(posedge clock) begin
        if (srst) begin
            sc_cnt_q      <= '0;
            quiet_q       <= '0;
            csf_d1_q      <= 1'b0;
            cs_in_pulse_q <= 1'b0;
        end else begin
            csf_d1_q <= csf_s;
            if (cs_rise) begin
                sc_cnt_q <= inc32(sc_cnt_q);
            end else if (quiet_q >= 8'(`ROFC_SC_QUIET_PULSES)) begin
                sc_cnt_q <= '0;
            end
            if (csf_s) begin
                quiet_q       <= '0;
                cs_in_pulse_q <= 1'b1;
            end else if (upper_pulse) begin
                cs_in_pulse_q <= 1'b0;
                if (!cs_in_pulse_q && quiet_q < 8'(`ROFC_SC_QUIET_PULSES)) begin
                    quiet_q <= quiet_q + 8'h01;
                end
            end
        end
    end

    // ************************************************************
    // protection mode
    // ************************************************************
    wire fault_hit = fb_confirm || sc_overflow;

    // latch or auto-recovery off-time
    always_ff @(posedge clock) begin
        if (srst) begin
            prot_q  <= 1'b0;
            latch_q <= 1'b0;
            arec_q  <= '0;
        end else if (latch_q) begin
            latch_q <= !supply_reset;
            prot_q  <= !supply_reset;
        end else if (fault_hit) begin
            prot_q  <= 1'b1;
            latch_q <= LATCHED;
            arec_q  <= '0;
        end else if (prot_q) begin
            arec_q <= inc32(arec_q);
            if (arec_q >= AREC_CYC - 32'h1) begin
                prot_q <= 1'b0;
            end
        end
    end

    assign stopped = prot_q || fault_hit || !run_enable;

    // ************************************************************
    // outputs
    // ************************************************************
    logic up_q;
    logic lo_q;
    logic ss_q;
    logic ff_q;

    // registered drives and steering
    always_ff @(posedge clock) begin
        if (srst) begin
            up_q <= 1'b0;
            lo_q <= 1'b0;
            ss_q <= 1'b1;
            ff_q <= 1'b0;
        end else begin
            up_q <= (phase_d == ROFC_ST_UPPER) && !stopped;
            lo_q <= (phase_d == ROFC_ST_LOWER) && !stopped;
            ss_q <= startup_active || prot_q;
            ff_q <= lok_s;
        end
    end

    assign gate_drive.upper          = up_q;
    assign gate_drive.lower          = lo_q;
    assign ref_soft_start_sel        = ss_q;
    assign feed_forward_current_en   = ff_q;
    assign fault_state.fault_latched = latch_q;
    assign fault_state.fault_recover = prot_q && !latch_q;
    assign on_time_last              = last_q;

endmodule : rofc_core

// File: rofc_defs.svh
// rofc_defs.svh: offsets-free constant set for the resonant on-time fault core
// assumes a 40 MHz core clock; included by the core, synchroniser, filter and checker files
`ifndef ROFC_DEFS_SVH
`define ROFC_DEFS_SVH

// ****************************************************************
// clock and time bases
// ****************************************************************
`define ROFC_CLK_PERIOD_PS   25000
`define ROFC_ON_STEP_NS      10
`define ROFC_FILT_ON_NS      2000
`define ROFC_FILT_OFF_NS     20000
`define ROFC_FILT_ON_CYC     ((`ROFC_FILT_ON_NS * 1000 + `ROFC_CLK_PERIOD_PS - 1) / `ROFC_CLK_PERIOD_PS)
`define ROFC_FILT_OFF_CYC    ((`ROFC_FILT_OFF_NS * 1000 + `ROFC_CLK_PERIOD_PS - 1) / `ROFC_CLK_PERIOD_PS)

// ****************************************************************
// widths, limits and defaults
// ****************************************************************
`define ROFC_ON_W            16
`define ROFC_FILT_W          10
`define ROFC_SC_QUIET_PULSES 50
`define ROFC_DEAD_CYC_DEF    8
`define ROFC_LEB_CYC_DEF     10
`define ROFC_FB_TIMER_DEF    40000
`define ROFC_FB_COUNT_DEF    1000
`define ROFC_SC_LIMIT_DEF    8
`define ROFC_AREC_CYC_DEF    40000

`endif

// File: rofc_pkg.sv
// rofc_pkg.sv: types shared by the resonant on-time fault core
// assumes nothing beyond a SystemVerilog compiler
package rofc_pkg;

    // ************************************************************
    // phase machine of the half bridge
    // ************************************************************
    typedef enum logic [4:0] {
        ROFC_ST_IDLE  = 5'h01,
        ROFC_ST_DT_HI = 5'h02,
        ROFC_ST_UPPER = 5'h04,
        ROFC_ST_DT_LO = 5'h08,
        ROFC_ST_LOWER = 5'h10
    } rofc_phase_t;

    // comparator group from the analog side
    typedef struct packed {
        logic on_time_trip;
        logic fb_fault;
        logic cs_fault;
        logic line_ok_flag;
    } rofc_cmp_t;

    // gate drive pair
    typedef struct packed {
        logic upper;
        logic lower;
    } rofc_gate_t;

    // status pair
    typedef struct packed {
        logic fault_latched;
        logic fault_recover;
    } rofc_fault_t;

endpackage : rofc_pkg

// File: rofc_sync.sv
// rofc_sync.sv: three-stage pin synchroniser with agreement check
// assumes the input is asynchronous to clock
`timescale 1ns/100ps
`include "rofc_defs.svh"

module rofc_sync
    import rofc_pkg::*;
(
    // clock and reset
    input  wire logic clock,
    input  wire logic srst,
    // pin side
    input  wire logic pin_in,
    // core side
    output logic      level_out
);

    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic level_q;

    // three flops; change taken once stages two and three agree
    always_ff @(posedge clock) begin
        s1_q <= pin_in;
        s2_q <= s1_q;
        s3_q <= s2_q;
        if (srst) begin
            level_q <= 1'b0;
        end else if (s2_q == s3_q) begin
            level_q <= s3_q;
        end
    end

    assign level_out = level_q;

endmodule : rofc_sync

// File: rofc_filter.sv
// rofc_filter.sv: asymmetric digital noise filter for the feedback fault
// assumes a synchronised input on the same clock
`timescale 1ns/100ps
`include "rofc_defs.svh"

module rofc_filter
    import rofc_pkg::*;
(
    // clock and reset
    input  wire logic clock,
    input  wire logic srst,
    // raw and filtered level
    input  wire logic raw_in,
    output logic      filt_out
);

    localparam logic [`ROFC_FILT_W-1:0] ON_CYC  = `ROFC_FILT_W'(`ROFC_FILT_ON_CYC);
    localparam logic [`ROFC_FILT_W-1:0] OFF_CYC = `ROFC_FILT_W'(`ROFC_FILT_OFF_CYC);

    logic [`ROFC_FILT_W-1:0] cnt_q;
    logic                    filt_q;
    wire                     differs = (raw_in != filt_q);
    wire  [`ROFC_FILT_W-1:0] limit   = filt_q ? OFF_CYC : ON_CYC;
    wire                     flip    = differs && (cnt_q == limit - `ROFC_FILT_W'(1));

    // count continuous disagreement; 2 us to set, 20 us to clear
    always_ff @(posedge clock) begin
        if (srst || !differs || flip) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + `ROFC_FILT_W'(1);
        end
        if (srst) begin
            filt_q <= 1'b0;
        end else if (flip) begin
            filt_q <= raw_in;
        end
    end

    assign filt_out = filt_q;

endmodule : rofc_filter

// File: rofc_partner.sv
// rofc_partner.sv: on-time comparator model facing the gate drives
// assumes the gate drive pair of rofc_core on the same clock
`timescale 1ns/100ps

module rofc_partner
    import rofc_pkg::*;
(
    // clock
    input  wire logic       clock,
    // gate side and trip point
    input  wire rofc_gate_t gate_drive,
    input  wire logic [7:0] trip_delay,
    // comparator pin
    output logic            on_time_trip
);
    // ********************
    // current ramp model
    // ********************
    logic [7:0] ramp_q;

    // ramp restarts with each upper pulse
    always_ff @(posedge clock) begin
        ramp_q <= gate_drive.upper ? ramp_q + 8'h01 : 8'h00;
    end

    // trip stays high until the upper switch opens
    assign on_time_trip = gate_drive.upper & (ramp_q >= trip_delay);
endmodule : rofc_partner

// File: rofc_core_asserts.sv
// rofc_core_asserts.sv: timing checker bound to rofc_core
// assumes one clock and the synchronous reset srst
`timescale 1ns/100ps
`include "rofc_defs.svh"

module rofc_core_asserts
    import rofc_pkg::*;
#(
    parameter int unsigned DEAD_CYC = 8,
    parameter int unsigned LEB_CYC  = 10
)(
    // clock and reset
    input wire logic                  clock,
    input wire logic                  srst,
    // core inputs
    input wire rofc_cmp_t             cmp_pins,
    input wire logic                  run_enable,
    input wire logic                  startup_active,
    input wire logic                  skip_mode,
    input wire logic                  supply_reset,
    // core outputs
    input wire rofc_gate_t            gate_drive,
    input wire logic                  ref_soft_start_sel,
    input wire logic                  feed_forward_current_en,
    input wire rofc_fault_t           fault_state,
    input wire logic [`ROFC_ON_W-1:0] on_time_last
);
    // ********************
    // gap and pulse lengths
    // ********************
    logic [7:0] off_q, up_q, lo_q;
    logic       up_v_q, lo_v_q;

    default clocking @(posedge clock); endclocking
    default disable iff (srst);

    // both-off gap saturates, pulse lengths hold after each pulse
    always_ff @(posedge clock) begin
        off_q  <= (srst | (|gate_drive)) ? 8'h00 : off_q + {7'h00, off_q != 8'hFF};
        up_v_q <= gate_drive.upper;
        lo_v_q <= gate_drive.lower;
        up_q   <= gate_drive.upper ? (up_v_q ? up_q + 8'h01 : 8'h01) : up_q;
        lo_q   <= gate_drive.lower ? (lo_v_q ? lo_q + 8'h01 : 8'h01) : lo_q;
    end

    // ********************
    // assertions
    // ********************
    AST_NO_OVERLAP: assert property (!(gate_drive.upper && gate_drive.lower))
        else $error("both gate drives high");
    AST_DEAD_UPPER: assert property ($rose(gate_drive.upper) |-> off_q >= DEAD_CYC)
        else $error("upper on before dead time ended");
    AST_DEAD_LOWER: assert property ($rose(gate_drive.lower) |-> off_q >= DEAD_CYC)
        else $error("lower on before dead time ended");
    AST_BLANKING: assert property ($fell(gate_drive.upper) && $past(run_enable)
        |=> $past(up_q) >= LEB_CYC || (|fault_state))
        else $error("upper pulse ended inside blanking");
    AST_EQUAL_LOWER: assert property ($fell(gate_drive.lower) && $past(run_enable)
        |=> $past(lo_q) == $past(up_q) || (|fault_state))
        else $error("lower pulse length differs from upper");
    AST_FAULT_GATES_OFF: assert property ((|fault_state) && (|$past(fault_state))
        |-> gate_drive == 2'h0)
        else $error("gate pulse during protection");
    AST_LATCH_HOLDS: assert property (fault_state.fault_latched && !supply_reset
        && !$past(supply_reset) |=> fault_state.fault_latched)
        else $error("latched protection released without supply reset");
    AST_LINE_OK_ON: assert property (cmp_pins.line_ok_flag [*8] |=> feed_forward_current_en)
        else $error("feed-forward current missing while line ok");
    AST_LINE_OK_OFF: assert property (!cmp_pins.line_ok_flag [*8] |=> !feed_forward_current_en)
        else $error("feed-forward current while line not ok");
    AST_SOFT_START: assert property (startup_active [*2] |-> ref_soft_start_sel)
        else $error("soft-start reference not selected in startup");
    AST_RESET: assert property (disable iff (1'b0) srst |=> gate_drive == 2'h0
        && fault_state == 2'h0 && ref_soft_start_sel && !feed_forward_current_en)
        else $error("outputs not cleared by reset");
endmodule : rofc_core_asserts

bind rofc_core rofc_core_asserts #(.DEAD_CYC(DEAD_CYC), .LEB_CYC(LEB_CYC)) i_asserts (
    .clock(clock), .srst(srst), .cmp_pins(cmp_pins), .run_enable(run_enable),
    .startup_active(startup_active), .skip_mode(skip_mode), .supply_reset(supply_reset),
    .gate_drive(gate_drive), .ref_soft_start_sel(ref_soft_start_sel),
    .feed_forward_current_en(feed_forward_current_en), .fault_state(fault_state),
    .on_time_last(on_time_last)
);

// File: resonant_ontime_fault_core_tb_top.sv
// resonant_ontime_fault_core_tb_top.sv: self-checking bench for rofc_core
// assumes rofc_partner as on-time comparator and the bound checker
`timescale 1ns/100ps

module resonant_ontime_fault_core_tb_top import rofc_pkg::*;;
    localparam int unsigned LEB      = 10;
    localparam int unsigned FB_TIMER = 1200;
    localparam int unsigned FILT_ON  = 80;

    // ********************
    // bench signals
    // ********************
    logic        clock, srst, trip, fb, cs, lok, run, sta, skp, sres;
    logic [7:0]  trip_dly;
    rofc_gate_t  gd;
    rofc_fault_t fst;
    logic        ref_sel, ff_en;
    logic [15:0] olast;
    int          fails = 0;
    int          tests_run = 0;

    rofc_core #(.USE_COUNTER(1'b0), .CUMULATIVE(1'b0), .LATCHED(1'b1), .DEAD_CYC(8),
        .LEB_CYC(LEB), .FB_TIMER_CYC(FB_TIMER), .FB_COUNT_LIM(5), .SC_LIMIT(3),
        .AREC_CYC(100)) i_dut (
        .clock(clock), .srst(srst), .cmp_pins({trip, fb, cs, lok}), .run_enable(run),
        .startup_active(sta), .skip_mode(skp), .supply_reset(sres), .gate_drive(gd),
        .ref_soft_start_sel(ref_sel), .feed_forward_current_en(ff_en),
        .fault_state(fst), .on_time_last(olast));

    rofc_partner i_partner (.clock(clock), .gate_drive(gd), .trip_delay(trip_dly),
        .on_time_trip(trip));

    // ********************
    // helpers
    // ********************
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask : tick

    // length of the next upper or lower pulse, bounded wait
    task automatic pulse(input bit up, output int n);
        int k;
        k = 0;
        n = 0;
        @(negedge clock);
        while ((up ? gd.upper : gd.lower) !== 1'b1 && k < 3000) begin
            @(negedge clock);
            k++;
        end
        while ((up ? gd.upper : gd.lower) === 1'b1 && n < 3000) begin
            @(negedge clock);
            n++;
        end
        @(posedge clock);
        check(16'(k < 3000), 16'h0001);
    endtask : pulse

    task automatic hold_fb(input int hi, input int lo);
        tick(1);
        fb <= 1'b1;
        tick(hi);
        fb <= 1'b0;
        tick(lo);
    endtask : hold_fb

    task automatic wait_fault(input int lim);
        int k;
        k = 0;
        while (fst === 2'h0 && k < lim) begin
            @(negedge clock);
            k++;
        end
    endtask : wait_fault

    task automatic sc_hit;
        int n;
        pulse(1'b1, n);
        cs <= 1'b1;
        tick(6);
        cs <= 1'b0;
    endtask : sc_hit

    // upper length follows the trip point, at most 8 cycles past it
    function automatic bit up_ok(input int n, input int d);
        return n >= d && n <= d + 8;
    endfunction : up_ok

    task automatic test_done;
        if (fails == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : test_done

    // ********************
    // clock, watchdog, sequence
    // ********************
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    initial begin
        #(40000 * 25);
        check(16'h0000, 16'h0001);
        test_done();
    end

    initial begin
        int n, m, prev, d;
        srst = 1'b1;
        {fb, cs, lok, run, sta, skp, sres} = 7'h00;
        trip_dly = 8'h1E;
        prev = 0;
        d = $urandom(32'h7B68900C);
        tick(6);
        srst <= 1'b0;
        @(negedge clock);
        check({10'h000, gd, ref_sel, ff_en, fst}, 16'h0008);
        tick(1);
        lok <= 1'b1;
        tick(12);
        check(16'(ff_en), 16'h0001);
        lok <= 1'b0;
        tick(12);
        check(16'(ff_en), 16'h0000);
        repeat (4) begin
            n = $urandom % 2;
            lok <= 1'(n);
            tick(12);
            check(16'(ff_en), 16'(n));
        end
        {lok, sta} <= 2'h3;
        tick(4);
        check(16'(ref_sel), 16'h0001);
        {sta, run} <= 2'h1;
        tick(4);
        check(16'(ref_sel), 16'h0000);
        // random trip points, then two early trips that must reuse the last length
        for (int i = 0; i < 7; i++) begin
            d = (i >= 5) ? 2 : 16 + ($urandom % 45);
            trip_dly <= 8'(d);
            sta <= 1'(d);
            pulse(1'b1, n);
            pulse(1'b0, m);
            check(16'(ref_sel), 16'(d % 2));
            check(olast, 16'(2 * (n - 1)));
            if (i >= 5) check(16'(n), 16'(prev));
            else check(16'(up_ok(n, d)), 16'h0001);
            check(16'(m), 16'(n));
            prev = n;
        end
        trip_dly <= 8'h14;
        hold_fb(40, 300);
        check(16'(fst), 16'h0000);
        hold_fb(230, 1000);
        hold_fb(230, 1000);
        check(16'(fst), 16'h0000);
        fb <= 1'b1;
        tick(230);
        skp <= 1'b1;
        tick(5);
        skp <= 1'b0;
        hold_fb(300, 1000);
        check(16'(fst), 16'h0000);
        fb <= 1'b1;
        tick(FILT_ON + FB_TIMER - 20);
        check(16'(fst), 16'h0000);
        wait_fault(80);
        check(16'(fst), 16'h0002);
        check(16'(gd), 16'h0000);
        tick(1);
        fb <= 1'b0;
        tick(1000);
        check({12'h000, gd, fst}, 16'h0002);
        sres <= 1'b1;
        tick(4);
        sres <= 1'b0;
        tick(3);
        check(16'(fst), 16'h0000);
        sc_hit();
        sc_hit();
        repeat (52) pulse(1'b1, n);
        sc_hit();
        sc_hit();
        tick(10);
        check(16'(fst), 16'h0000);
        sc_hit();
        wait_fault(60);
        check(16'(fst), 16'h0002);
        test_done();
    end
endmodule : resonant_ontime_fault_core_tb_top
